// ==== dmp_map.svh ====
// Register offsets, field positions, reset values and timing in ns
`ifndef DMP_MAP_SVH
`define DMP_MAP_SVH
`define DMP_OFF_CTRL      12'h000
`define DMP_OFF_CHCFG0    12'h004
`define DMP_OFF_CHCFG1    12'h008
`define DMP_OFF_PERIOD0   12'h00c
`define DMP_OFF_PERIOD1   12'h010
`define DMP_OFF_PULSE0    12'h014
`define DMP_OFF_PULSE1    12'h018
`define DMP_OFF_STATUS    12'h01c
`define DMP_OFF_REC_NUM   12'h020
`define DMP_REC_HS        8'h80
`define DMP_CTRL_PARALLEL 0
`define DMP_CF_PERMIT     0
`define DMP_CF_INTERP_LO  1
`define DMP_CF_DIR        3
`define DMP_CF_HS         4
`define DMP_CF_DELAY_LO   8
`define DMP_CF_MODE_LO    12
`define DMP_CF_RESET      32'h0000_0000
`define DMP_PERIOD_RESET  32'h0000_03e8
`define DMP_PULSE_RESET   32'h0000_0000
`define DMP_DLY_TICK_NS   100000
`define DMP_CLK_NS        100
`endif

// ==== dmp_pkg.sv ====
// Types shared by the motor PWM drive files
package dmp_pkg;
  typedef enum logic [1:0] {
    DMP_DI_INPUT, DMP_DI_RUN_GATE, DMP_DI_EXT_STOP, DMP_DI_RSVD
  } dmp_interp_t;
  typedef enum logic [2:0] {
    DMP_M_PULSE, DMP_M_PWM, DMP_M_TRAIN, DMP_M_DELAY, DMP_M_FREQ,
    DMP_M_DCMOTOR, DMP_M_RSVD6, DMP_M_RSVD7
  } dmp_mode_t;
  typedef struct packed {
    logic        forward_drive_out;
    logic        backward_drive_out;
  } dmp_drive_t;
  typedef struct packed {
    logic        software_run_permit;
    dmp_interp_t input_interpretation_select;
    logic        backward;
    logic        high_speed;
    logic [2:0]  delay_sel;
    dmp_mode_t   mode;
    logic [31:0] period;
    logic [31:0] pulse;
  } dmp_chan_cfg_t;
  typedef struct packed {
    logic        sequence_running_flag;
    logic        filtered_in;
    dmp_drive_t  drive;
    logic [3:0]  completed_sequence_counter;
  } dmp_chan_sts_t;
endpackage

// ==== dmp_in_filter.sv ====
// Selectable-delay noise filter with edge detection for the digital input
`timescale 1ns/1ps
`include "dmp_map.svh"
module dmp_in_filter
  import dmp_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Raw input and delay choice
  input  wire logic       raw_in,
  input  wire logic [2:0] delay_sel,
  // Filtered level and edges
  output logic            level_q,
  output logic            rise_q,
  output logic            fall_q
);
  localparam int TICK_CYC = (`DMP_DLY_TICK_NS + `DMP_CLK_NS - 1) / `DMP_CLK_NS;
  logic [9:0]  tick_cnt_q;
  logic        tick;
  logic [7:0]  stable_cnt_q;
  logic [7:0]  need;

  // Delay 0 passes every sample; others need 2**sel ticks of stability
  assign need = (delay_sel == 3'h0) ? 8'h00 : 8'(8'h01 << delay_sel);
  assign tick = (tick_cnt_q == 10'(TICK_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 10'h000;
    end else if (tick) begin
      tick_cnt_q <= 10'h000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_cnt_q <= 8'h00;
      level_q      <= 1'b0;
      rise_q       <= 1'b0;
      fall_q       <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (raw_in == level_q) begin
        stable_cnt_q <= 8'h00;
      end else if (stable_cnt_q >= need) begin
        stable_cnt_q <= 8'h00;
        level_q      <= raw_in;
        rise_q       <= raw_in;
        fall_q       <= !raw_in;
      end else if (tick) begin
        stable_cnt_q <= stable_cnt_q + 8'h01;
      end
    end
  end
endmodule // dmp_in_filter

// ==== dmp_channel.sv ====
// One motor drive channel: sequence control and PWM with direction
`timescale 1ns/1ps
`include "dmp_map.svh"
module dmp_channel
  import dmp_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Configuration and input
  input  dmp_pkg::dmp_chan_cfg_t cfg,
  input  wire logic          raw_in,
  // Status and drive
  output dmp_pkg::dmp_chan_sts_t sts
);
  logic        lvl, rise, fall;
  logic        run_q;
  logic [31:0] cnt_q;
  logic        last_dir_q;
  logic        dead_q;
  dmp_drive_t  drv_q;

  dmp_in_filter u_filt (
    .pclk      (pclk),
    .presetn   (presetn),
    .raw_in    (raw_in),
    .delay_sel (cfg.delay_sel),
    .level_q   (lvl),
    .rise_q    (rise),
    .fall_q    (fall)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (!cfg.software_run_permit) begin
      run_q <= 1'b0;
    end else begin
      unique case (cfg.input_interpretation_select)
        DMP_DI_RUN_GATE: begin
          if (rise) run_q <= 1'b1;
          else if (fall) run_q <= 1'b0;
        end
        DMP_DI_EXT_STOP: begin
          if (rise) run_q <= 1'b0;
          else if (!run_q && !lvl) run_q <= 1'b1;
        end
        default: run_q <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0000_0000;
    end else if (!run_q || cnt_q + 32'h1 >= cfg.period) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_dir_q <= 1'b0;
      dead_q     <= 1'b0;
    end else begin
      last_dir_q <= cfg.backward;
      dead_q     <= (last_dir_q != cfg.backward);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_q <= '0;
    end else if (!run_q || dead_q || last_dir_q != cfg.backward ||
                 cnt_q >= cfg.pulse) begin
      drv_q <= '0;
    end else begin
      drv_q.forward_drive_out  <= !cfg.backward;
      drv_q.backward_drive_out <= cfg.backward;
    end
  end

  always_comb begin
    sts.sequence_running_flag      = run_q;
    sts.filtered_in                = lvl;
    sts.drive                      = drv_q;
    sts.completed_sequence_counter = 4'h0;
  end
endmodule // dmp_channel

// ==== dmp_top.sv ====
// Two-channel DC motor PWM drive with APB register access
//
// Summary of operation
// - Gate rise starts sequence after delay
// - Gate fall stops sequence after delay
// - External stop rise halts sequence
// - Input filtered by selectable delay
// - Idle or interpulse: both outputs low
// - Forward pulse drives first output only
// - Backward pulse drives second output only
// - Pulses repeat at period with duty
// - High-speed only in two-channel operation
// - High-speed per channel, record 128; record number is not checked here
// - Parallel mode locks channel 1, high-speed
// - High-speed allowed in five pulse modes
// - High-speed refused in DC motor mode
// - Running flag mirrors sequence state
// - Sequence counter stays zero here
`timescale 1ns/1ps
`include "dmp_map.svh"
module dmp_top
  import dmp_pkg::*;
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Digital inputs
  input  wire logic [1:0]  raw_in,
  // Motor outputs
  output logic [1:0]       forward_drive_out,
  output logic [1:0]       backward_drive_out,
  output logic [1:0]       sequence_running_flag
);
  logic          parallel_q;
  logic [31:0]   chcfg_q  [2];
  logic [31:0]   period_q [2];
  logic [31:0]   pulse_q  [2];
  logic [7:0]    rec_num_q;
  logic          wr_en, rd_en;
  dmp_chan_cfg_t cfg [2];
  dmp_chan_sts_t sts [2];

  // High-speed only in the five pulse modes, never in DC motor mode
  function automatic logic hs_mode_ok(input logic [2:0] m);
    return (m <= 3'(DMP_M_FREQ));
  endfunction

  function automatic logic [31:0] cfg_filter(input logic [31:0] v,
                                              input logic        par);
    logic [31:0] r;
    r = v;
    if (par || !hs_mode_ok(v[`DMP_CF_MODE_LO +: 3])) begin
      r[`DMP_CF_HS] = 1'b0;
    end
    return r;
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parallel_q <= 1'b0;
      rec_num_q  <= 8'h00;
    end else if (wr_en && paddr == `DMP_OFF_CTRL) begin
      parallel_q <= pwdata[`DMP_CTRL_PARALLEL];
    end else if (wr_en && paddr == `DMP_OFF_REC_NUM) begin
      rec_num_q <= pwdata[7:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      localparam logic [11:0] OC = (g == 0) ? `DMP_OFF_CHCFG0
                                            : `DMP_OFF_CHCFG1;
      localparam logic [11:0] OP = (g == 0) ? `DMP_OFF_PERIOD0
                                            : `DMP_OFF_PERIOD1;
      localparam logic [11:0] OW = (g == 0) ? `DMP_OFF_PULSE0
                                            : `DMP_OFF_PULSE1;
      logic locked;
      assign locked = (g == 1) && parallel_q;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chcfg_q[g]  <= `DMP_CF_RESET;
          period_q[g] <= `DMP_PERIOD_RESET;
          pulse_q[g]  <= `DMP_PULSE_RESET;
        end else if (locked) begin
          chcfg_q[g] <= `DMP_CF_RESET;
        end else if (wr_en && paddr == OC) begin
          chcfg_q[g] <= cfg_filter(pwdata, parallel_q);
        end else if (wr_en && paddr == OP) begin
          period_q[g] <= pwdata;
        end else if (wr_en && paddr == OW) begin
          pulse_q[g] <= pwdata;
        end else begin
          // Record number is kept for software only; it gates nothing
          // Parallel or mode changes withdraw a stale high-speed bit
          chcfg_q[g] <= cfg_filter(chcfg_q[g], parallel_q);
        end
      end

      always_comb begin
        cfg[g].software_run_permit = chcfg_q[g][`DMP_CF_PERMIT];
        cfg[g].input_interpretation_select =
          dmp_interp_t'(chcfg_q[g][`DMP_CF_INTERP_LO +: 2]);
        cfg[g].backward   = chcfg_q[g][`DMP_CF_DIR];
        cfg[g].high_speed = chcfg_q[g][`DMP_CF_HS];
        cfg[g].delay_sel  = chcfg_q[g][`DMP_CF_DELAY_LO +: 3];
        cfg[g].mode       = dmp_mode_t'(chcfg_q[g][`DMP_CF_MODE_LO +: 3]);
        cfg[g].period     = period_q[g];
        cfg[g].pulse      = pulse_q[g];
      end

      dmp_channel u_ch (
        .pclk    (pclk),
        .presetn (presetn),
        .cfg     (cfg[g]),
        .raw_in  (raw_in[g]),
        .sts     (sts[g])
      );

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          forward_drive_out[g]     <= 1'b0;
          backward_drive_out[g]    <= 1'b0;
          sequence_running_flag[g] <= 1'b0;
        end else begin
          forward_drive_out[g]     <= sts[g].drive.forward_drive_out;
          backward_drive_out[g]    <= sts[g].drive.backward_drive_out;
          sequence_running_flag[g] <= sts[g].sequence_running_flag;
        end
      end
    end
  endgenerate

  function automatic logic [7:0] sts_byte(input dmp_chan_sts_t s);
    return {s.completed_sequence_counter, s.filtered_in,
            s.drive.backward_drive_out, s.drive.forward_drive_out,
            s.sequence_running_flag};
  endfunction

  // Read data registered in setup; answer in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `DMP_OFF_REC_NUM ||
                                      paddr[1:0] != 2'h0);
      if (rd_en) begin
        unique case (paddr)
          `DMP_OFF_CTRL:    prdata <= {31'h0, parallel_q};
          `DMP_OFF_CHCFG0:  prdata <= chcfg_q[0];
          `DMP_OFF_CHCFG1:  prdata <= chcfg_q[1];
          `DMP_OFF_PERIOD0: prdata <= period_q[0];
          `DMP_OFF_PERIOD1: prdata <= period_q[1];
          `DMP_OFF_PULSE0:  prdata <= pulse_q[0];
          `DMP_OFF_PULSE1:  prdata <= pulse_q[1];
          `DMP_OFF_STATUS:  prdata <= {16'h0, sts_byte(sts[1]),
                                       sts_byte(sts[0])};
          `DMP_OFF_REC_NUM: prdata <= {24'h0, rec_num_q};
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // dmp_top

// ==== dmp_top_asserts.sv ====
// Port-level assertions for the motor PWM drive top
`timescale 1ns/1ps
module dmp_top_asserts (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Motor side
  input wire logic [1:0]  raw_in,
  input wire logic [1:0]  forward_drive_out,
  input wire logic [1:0]  backward_drive_out,
  input wire logic [1:0]  sequence_running_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero wait states: the access cycle always completes
  sequence s_setup;
    psel && !penable;
  endsequence
  a_ready_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_unmapped: assert property (pready && paddr > 12'h020 |-> pslverr)
    else $error("unmapped address accepted");
  a_err_rdzero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_ok_mapped: assert property (pready && paddr <= 12'h020
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped refused");
  // Never a shorted bridge, even while reversing
  a_no_both: assert property (
    !(|(forward_drive_out & backward_drive_out)))
    else $error("both outputs active");
  a_idle_low: assert property (!sequence_running_flag[0] [*3] |->
    !forward_drive_out[0] && !backward_drive_out[0])
    else $error("output while idle");
endmodule // dmp_top_asserts
bind dmp_top dmp_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .raw_in(raw_in), .forward_drive_out(forward_drive_out),
  .backward_drive_out(backward_drive_out),
  .sequence_running_flag(sequence_running_flag));

// ==== dmp_load_model.sv ====
// Motor load and digital input source seen by the drive
`timescale 1ns/1ps
module dmp_load_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Commands from the bench
  input  wire logic [1:0] cmd_in,
  input  wire logic       clr,
  // Drive outputs of channel 0
  input  wire logic       fwd,
  input  wire logic       back,
  // Input line and active-cycle counts
  output logic      [1:0] raw_in,
  output logic      [15:0] fwd_cnt,
  output logic      [15:0] back_cnt
);
  // Input switches like a contact, synchronous to the bus clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) raw_in <= 2'h0;
    else raw_in <= cmd_in;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_cnt  <= 16'h0;
      back_cnt <= 16'h0;
    end else if (clr) begin
      fwd_cnt  <= 16'h0;
      back_cnt <= 16'h0;
    end else begin
      fwd_cnt  <= fwd_cnt + 16'(fwd);
      back_cnt <= back_cnt + 16'(back);
    end
  end
endmodule // dmp_load_model

// ==== tb.sv ====
// Self-checking bench for the motor PWM drive
`timescale 1ns/1ps
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, clr = 0, er;
  logic [1:0]  raw_in, fwd, back, run, cmd = 2'h0;
  logic [15:0] fc, bc;
  int          bad_count = 0, check_count = 0;
  always #50 pclk = ~pclk;
  dmp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_in(raw_in),
    .forward_drive_out(fwd), .backward_drive_out(back),
    .sequence_running_flag(run));
  dmp_load_model m (.pclk(pclk), .presetn(presetn), .cmd_in(cmd),
    .clr(clr), .fwd(fwd[0]), .back(back[0]), .raw_in(raw_in),
    .fwd_cnt(fc), .back_cnt(bc));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    // Start on a fresh edge so a back-to-back call never re-drives psel
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task t_regs;
    apb(0, 12'h004, 0); chk(rd, 32'h0);
    apb(0, 12'h00c, 0); chk(rd, 32'h3e8); chk(er, 32'h0);
    apb(0, 12'h024, 0); chk(rd, 32'h0); chk(er, 32'h1);
    apb(1, 12'h024, 32'h5); chk(er, 32'h1);
    $display("test regs done");
  endtask
  // Ten-cycle period, four cycles on, counted over two periods
  task t_pwm(input logic dir);
    apb(1, 12'h00c, 32'd10); apb(1, 12'h014, 32'd4);
    apb(1, 12'h004, dir ? 32'h5009 : 32'h5001);
    wait_n(12); clr <= 1; @(posedge pclk); clr <= 0;
    wait_n(20);
    chk({fc, bc}, dir ? {16'd0, 16'd8} : {16'd8, 16'd0});
    apb(0, 12'h01c, 0);
    chk(rd[7:4], 32'h0);
    chk(rd[0], 32'h1);
    $display("test pwm done");
  endtask
  // Gate on channel 1 through the shortest non-zero filter
  task t_gate;
    apb(1, 12'h004, 32'h0); apb(1, 12'h008, 32'h5103);
    wait_n(5); chk(run[1], 32'h0);
    cmd[1] <= 1;
    wait_n(900); chk(run[1], 32'h0);
    wait_n(3000); chk(run[1], 32'h1);
    cmd[1] <= 0;
    wait_n(3500); chk({run[1], fwd[1], back[1]}, 32'h0);
    $display("test gate done");
  endtask
  task t_stop;
    apb(1, 12'h004, 32'h5005);
    wait_n(10); chk(run[0], 32'h1);
    cmd[0] <= 1;
    wait_n(10); chk(run[0], 32'h0);
    $display("test stop done");
  endtask
  task t_hs;
    apb(1, 12'h004, 32'h5011); apb(0, 12'h004, 0); chk(rd, 32'h5001);
    apb(1, 12'h004, 32'h1011); apb(0, 12'h004, 0); chk(rd, 32'h1011);
    apb(1, 12'h020, 32'h80); apb(1, 12'h008, 32'h1001);
    apb(0, 12'h008, 0); chk(rd, 32'h1001);
    apb(0, 12'h004, 0); chk(rd, 32'h1011);
    apb(1, 12'h000, 32'h1); apb(1, 12'h008, 32'h1001);
    apb(0, 12'h004, 0); chk(rd, 32'h1001);
    apb(0, 12'h008, 0); chk(rd, 32'h0);
    apb(1, 12'h000, 32'h0);
    $display("test high speed done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs; t_pwm(0); t_pwm(1); t_gate; t_stop; t_hs;
    stop_test;
  end
  // Whole run needs about 8000 cycles
  initial begin
    repeat (15000) @(posedge pclk);
    bad_count++;
    stop_test;
  end
endmodule // tb
